// file: rtl/rx_filter_pkg.sv
// Constants, register map and carrier types for the receive address filter.
// Assumes a 32-bit APB register bus and a byte-wide receive stream from the MAC.
package rx_filter_pkg;

	// ----------------------------------------
	// Register indices (byte address = index * 4)
	// ----------------------------------------
	localparam logic [5:0] IDX_RECEIVE_CONFIG = 6'h0C;
	localparam logic [5:0] IDX_MAC_CONFIG = 6'h1B;
	localparam logic [5:0] IDX_TAG_ID_LOW = 6'h1C;
	localparam logic [5:0] IDX_TAG_ID_HIGH = 6'h1D;
	localparam logic [5:0] IDX_STATION_BASE = 6'h01;
	localparam logic [5:0] IDX_HASH_BASE = 6'h10;
	localparam logic [5:0] IDX_FILTER_STATUS = 6'h1E;
	localparam int STATION_BYTES = 6;
	localparam int HASH_BYTES = 8;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int RC_ACCEPT_ALL_ONES_BIT = 2;
	localparam int RC_ACCEPT_GROUP_BIT = 3;
	localparam int RC_PROMISCUOUS_BIT = 4;
	localparam int MC_TAG_FILTER_EN_BIT = 0;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ----------------------------------------
	// Frame layout and limits
	// ----------------------------------------
	localparam logic [10:0] LAST_DA_INDEX = 11'h005;
	localparam logic [10:0] TAG_HIGH_INDEX = 11'h00C;
	localparam logic [10:0] TAG_LOW_INDEX = 11'h00D;
	localparam logic [10:0] MAX_LEN_PLAIN = 11'h5EE;
	localparam logic [10:0] MAX_LEN_TAGGED = 11'h5F2;
	localparam logic [10:0] LEN_SATURATE = 11'h7FF;
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic [7:0] data;
	} rx_byte_s;

	typedef struct packed {
		logic decision_valid;
		logic overall_accept;
		logic unicast_hit;
		logic multicast_hit;
		logic broadcast_hit;
		logic tag_id_hit;
		logic length_error;
	} filter_result_s;

endpackage : rx_filter_pkg

// file: rtl/rx_address_filter.sv
// Receive destination address filter with APB register access.
// Assumes the MAC delivers one byte per valid cycle, sof on the first, eof on the last.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rx_address_filter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rx_filter_pkg::rx_byte_s rx_in,
	output rx_filter_pkg::filter_result_s result
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] receive_config_reg;
	logic [7:0] mac_config_reg;
	logic [7:0] tag_id_low_reg;
	logic [7:0] tag_id_high_reg;
	logic [7:0] station_reg [rx_filter_pkg::STATION_BYTES];
	logic [7:0] hash_reg [rx_filter_pkg::HASH_BYTES];
	logic [63:0] hash_filter_bits;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [4:0] status_bits_reg;
	logic [5:0] status_index_reg;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic [5:0] bus_idx;
	logic bus_aligned;
	logic bus_mapped;
	logic bus_write;
	logic [31:0] read_next;

	assign bus_idx = paddr[7:2];
	assign bus_aligned = (paddr[1:0] == 2'b00);
	assign bus_write = psel && penable && pready_reg && pwrite && bus_mapped;

	always_comb begin
		bus_mapped = bus_aligned;
		read_next = 32'h00000000;
		if (bus_idx == rx_filter_pkg::IDX_RECEIVE_CONFIG) begin
			read_next[7:0] = receive_config_reg;
		end else if (bus_idx == rx_filter_pkg::IDX_MAC_CONFIG) begin
			read_next[7:0] = mac_config_reg;
		end else if (bus_idx == rx_filter_pkg::IDX_TAG_ID_LOW) begin
			read_next[7:0] = tag_id_low_reg;
		end else if (bus_idx == rx_filter_pkg::IDX_TAG_ID_HIGH) begin
			read_next[7:0] = tag_id_high_reg;
		end else if (bus_idx == rx_filter_pkg::IDX_FILTER_STATUS) begin
			read_next = {18'h00000, status_index_reg, 3'b000, status_bits_reg};
		end else if (bus_idx >= rx_filter_pkg::IDX_STATION_BASE &&
				bus_idx < rx_filter_pkg::IDX_STATION_BASE + 6'(rx_filter_pkg::STATION_BYTES)) begin
			read_next[7:0] = station_reg[3'(bus_idx - rx_filter_pkg::IDX_STATION_BASE)];
		end else if (bus_idx >= rx_filter_pkg::IDX_HASH_BASE &&
				bus_idx < rx_filter_pkg::IDX_HASH_BASE + 6'(rx_filter_pkg::HASH_BYTES)) begin
			read_next[7:0] = hash_reg[3'(bus_idx - rx_filter_pkg::IDX_HASH_BASE)];
		end else begin
			bus_mapped = 1'b0;
		end
	end

	// One wait-free access phase: answer is prepared during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= psel && !penable;
			pslverr_reg <= psel && !penable && !bus_mapped;
			if (psel && !penable) begin
				prdata_reg <= (pwrite || !bus_mapped) ? 32'h00000000 : read_next;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_config_reg <= rx_filter_pkg::REG_RESET;
			mac_config_reg <= rx_filter_pkg::REG_RESET;
			tag_id_low_reg <= rx_filter_pkg::REG_RESET;
			tag_id_high_reg <= rx_filter_pkg::REG_RESET;
		end else if (bus_write) begin
			if (bus_idx == rx_filter_pkg::IDX_RECEIVE_CONFIG) begin
				receive_config_reg <= pwdata[7:0];
			end
			if (bus_idx == rx_filter_pkg::IDX_MAC_CONFIG) begin
				mac_config_reg <= pwdata[7:0];
			end
			if (bus_idx == rx_filter_pkg::IDX_TAG_ID_LOW) begin
				tag_id_low_reg <= pwdata[7:0];
			end
			if (bus_idx == rx_filter_pkg::IDX_TAG_ID_HIGH) begin
				tag_id_high_reg <= pwdata[7:0];
			end
		end
	end

	// Station address and hash bytes, one flop group per entry
	genvar gi;
	generate
		for (gi = 0; gi < rx_filter_pkg::HASH_BYTES; gi++) begin : g_hash
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hash_reg[gi] <= rx_filter_pkg::REG_RESET;
				end else if (bus_write && bus_idx == rx_filter_pkg::IDX_HASH_BASE + 6'(gi)) begin
					hash_reg[gi] <= pwdata[7:0];
				end
			end
			assign hash_filter_bits[gi*8 +: 8] = hash_reg[gi];
			if (gi < rx_filter_pkg::STATION_BYTES) begin : g_station
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						station_reg[gi] <= rx_filter_pkg::REG_RESET;
					end else if (bus_write && bus_idx == rx_filter_pkg::IDX_STATION_BASE + 6'(gi)) begin
						station_reg[gi] <= pwdata[7:0];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Frame tracking
	// ----------------------------------------
	logic [10:0] byte_cnt_reg;
	logic [10:0] cur_idx;
	logic [10:0] frame_len;
	logic [31:0] crc_reg;
	logic [31:0] crc_next;
	logic [5:0] hash_index_reg;
	logic unicast_ok_reg;
	logic all_ones_reg;
	logic group_reg;
	logic [7:0] tag_high_byte_reg;
	logic tag_hit_reg;

	assign cur_idx = rx_in.sof ? 11'h000 : byte_cnt_reg;
	assign frame_len = (cur_idx == rx_filter_pkg::LEN_SATURATE) ? cur_idx : cur_idx + 11'h001;

	function automatic logic [31:0] crc_byte(input logic [31:0] crc_in, input logic [7:0] d);
		logic [31:0] c;
		logic fb;
		c = crc_in;
		for (int i = 0; i < 8; i++) begin
			fb = c[31] ^ d[i];
			c = {c[30:0], 1'b0} ^ (fb ? rx_filter_pkg::CRC_POLY : 32'h00000000);
		end
		return c;
	endfunction : crc_byte

	assign crc_next = crc_byte(rx_in.sof ? rx_filter_pkg::CRC_INIT : crc_reg, rx_in.data);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_cnt_reg <= 11'h000;
		end else if (rx_in.valid) begin
			byte_cnt_reg <= rx_in.eof ? 11'h000 : frame_len;
		end
	end

	// Only the destination bytes enter the hash CRC
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_reg <= rx_filter_pkg::CRC_INIT;
			hash_index_reg <= 6'h00;
		end else if (rx_in.valid && cur_idx <= rx_filter_pkg::LAST_DA_INDEX) begin
			crc_reg <= crc_next;
			if (cur_idx == rx_filter_pkg::LAST_DA_INDEX) begin
				hash_index_reg <= crc_next[31:26];
			end
		end
	end

	// Destination address comparisons, byte by byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unicast_ok_reg <= 1'b0;
			all_ones_reg <= 1'b0;
			group_reg <= 1'b0;
		end else if (rx_in.valid && cur_idx <= rx_filter_pkg::LAST_DA_INDEX) begin
			unicast_ok_reg <= (rx_in.sof || unicast_ok_reg) &&
				(rx_in.data == station_reg[3'(cur_idx)]);
			all_ones_reg <= (rx_in.sof || all_ones_reg) && (rx_in.data == 8'hFF);
			if (rx_in.sof) begin
				group_reg <= rx_in.data[0];
			end
		end
	end

	// Tag identifier bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag_high_byte_reg <= 8'h00;
			tag_hit_reg <= 1'b0;
		end else if (rx_in.valid) begin
			if (rx_in.sof) begin
				tag_hit_reg <= 1'b0;
			end else if (cur_idx == rx_filter_pkg::TAG_HIGH_INDEX) begin
				tag_high_byte_reg <= rx_in.data;
			end else if (cur_idx == rx_filter_pkg::TAG_LOW_INDEX) begin
				tag_hit_reg <= (tag_high_byte_reg == tag_id_high_reg && rx_in.data == tag_id_low_reg) ||
					(tag_high_byte_reg == 8'h00 && rx_in.data == 8'h00);
			end
		end
	end

	// ----------------------------------------
	// Decision
	// ----------------------------------------
	logic tag_filter_enable;
	logic accept_all_ones_dest;
	logic accept_group_dest;
	logic promiscuous_accept;
	logic uni_hit;
	logic mul_hit;
	logic bro_hit;
	logic overall_accept;
	logic [10:0] max_len;
	rx_filter_pkg::filter_result_s result_reg;
	logic [10:0] last_len_reg;

	assign tag_filter_enable = mac_config_reg[rx_filter_pkg::MC_TAG_FILTER_EN_BIT];
	assign accept_all_ones_dest = receive_config_reg[rx_filter_pkg::RC_ACCEPT_ALL_ONES_BIT];
	assign accept_group_dest = receive_config_reg[rx_filter_pkg::RC_ACCEPT_GROUP_BIT];
	assign promiscuous_accept = receive_config_reg[rx_filter_pkg::RC_PROMISCUOUS_BIT];
	assign uni_hit = unicast_ok_reg && !group_reg;
	assign mul_hit = group_reg && hash_filter_bits[hash_index_reg];
	assign bro_hit = all_ones_reg;
	assign overall_accept = (uni_hit || (mul_hit && accept_group_dest) ||
		(bro_hit && accept_all_ones_dest) || promiscuous_accept) &&
		(tag_hit_reg || !tag_filter_enable);
	assign max_len = tag_filter_enable ? rx_filter_pkg::MAX_LEN_TAGGED : rx_filter_pkg::MAX_LEN_PLAIN;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= '0;
			last_len_reg <= 11'h000;
		end else begin
			result_reg.decision_valid <= rx_in.valid && rx_in.eof;
			if (rx_in.valid && rx_in.eof) begin
				result_reg.overall_accept <= overall_accept;
				result_reg.unicast_hit <= uni_hit;
				result_reg.multicast_hit <= mul_hit;
				result_reg.broadcast_hit <= bro_hit;
				result_reg.tag_id_hit <= tag_hit_reg;
				result_reg.length_error <= frame_len > max_len;
				last_len_reg <= frame_len;
			end
		end
	end

	// Last decision held for software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_bits_reg <= 5'h00;
			status_index_reg <= 6'h00;
		end else if (result_reg.decision_valid) begin
			status_bits_reg <= {result_reg.tag_id_hit, result_reg.broadcast_hit, result_reg.multicast_hit,
				result_reg.unicast_hit, result_reg.overall_accept};
			status_index_reg <= hash_index_reg;
		end
	end

	assign result = result_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_unicast_byte_miss: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && cur_idx <= rx_filter_pkg::LAST_DA_INDEX && rx_in.data != station_reg[3'(cur_idx)]
		|=> !unicast_ok_reg)
		else $error("unicast match survived a differing byte");

	a_hash_index_hold: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && !rx_in.sof && cur_idx > rx_filter_pkg::LAST_DA_INDEX |=> $stable(hash_index_reg))
		else $error("hash index changed after the destination field");

	a_group_hash_hit: assert property (@(posedge pclk) disable iff (!presetn)
		result_reg.decision_valid && result_reg.multicast_hit |-> hash_filter_bits[hash_index_reg])
		else $error("group match without a set filter bit");

	a_group_first_bit: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && rx_in.sof ##1 (!rx_in.valid || !rx_in.sof) [*2] |-> group_reg == $past(rx_in.data[0], 2))
		else $error("group flag not taken from the first received bit");

	a_all_ones_miss: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && cur_idx <= rx_filter_pkg::LAST_DA_INDEX && rx_in.data != 8'hFF |=> !all_ones_reg)
		else $error("broadcast flag survived a zero bit");

	a_tag_zero_pass: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && !rx_in.sof && cur_idx == rx_filter_pkg::TAG_LOW_INDEX && rx_in.data == 8'h00 &&
		tag_high_byte_reg == 8'h00 |=> tag_hit_reg)
		else $error("zero tag identifier was rejected");

	a_length_limit: assert property (@(posedge pclk) disable iff (!presetn)
		result_reg.decision_valid && !$past(tag_filter_enable) |->
		result_reg.length_error == (last_len_reg > rx_filter_pkg::MAX_LEN_PLAIN))
		else $error("length check used the wrong limit");

	a_decision_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && rx_in.eof |=> result_reg.decision_valid ##1
		(!result_reg.decision_valid || $past(rx_in.valid && rx_in.eof)))
		else $error("decision not issued one cycle after end of frame");

	a_tag_reject: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && rx_in.eof && tag_filter_enable && !tag_hit_reg |=> !result_reg.overall_accept)
		else $error("frame accepted despite tag mismatch");

	a_unicast_accept: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && rx_in.eof && uni_hit && !tag_filter_enable |=> result_reg.overall_accept)
		else $error("unicast match not accepted");

	a_tag_id_miss: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && !rx_in.sof && cur_idx == rx_filter_pkg::TAG_LOW_INDEX && rx_in.data != tag_id_low_reg &&
		(tag_high_byte_reg != 8'h00 || rx_in.data != 8'h00) |=> !tag_hit_reg)
		else $error("tag identifier mismatch was passed");

	a_tag_length_limit: assert property (@(posedge pclk) disable iff (!presetn)
		result_reg.decision_valid && $past(tag_filter_enable) |->
		result_reg.length_error == (last_len_reg > rx_filter_pkg::MAX_LEN_TAGGED))
		else $error("tagged length check used the wrong limit");

	a_hash_capture: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && cur_idx == rx_filter_pkg::LAST_DA_INDEX |=> hash_index_reg == $past(crc_next[31:26]))
		else $error("hash index not taken after the last destination byte");

	a_group_hash_miss: assert property (@(posedge pclk) disable iff (!presetn)
		result_reg.decision_valid && !hash_filter_bits[hash_index_reg] |-> !result_reg.multicast_hit)
		else $error("group match with a clear filter bit");

	a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(rx_in.valid && rx_in.eof) |=> result_reg.overall_accept == $past(result_reg.overall_accept))
		else $error("decision changed without an end of frame");

	a_promiscuous_pass: assert property (@(posedge pclk) disable iff (!presetn)
		rx_in.valid && rx_in.eof && promiscuous_accept && !tag_filter_enable |=> result_reg.overall_accept)
		else $error("promiscuous mode rejected a frame");

endmodule : rx_address_filter

`default_nettype wire

// file: tb/rx_mac_source.sv
// Behavioural model of the MAC receive datapath that feeds the filter.
// Assumes it shares pclk with the filter; the bench loads buf_q and calls send.
`timescale 1ns/1ps
`default_nettype none

module rx_mac_source (
	input wire logic pclk,
	output var rx_filter_pkg::rx_byte_s rx_out
);
	logic [7:0] buf_q[$];

	initial rx_out = '0;

	// ----------------------------------------
	// Frame streaming, first wire byte first
	// ----------------------------------------
	// Gap cycles show inverted data so stale bytes are never mistaken for valid ones
	task automatic send(input int gap);
		for (int i = 0; i < buf_q.size(); i++) begin
			@(posedge pclk);
			rx_out <= {1'b1, i == 0, i == buf_q.size() - 1, buf_q[i]};
			for (int g = 0; g < gap && i < buf_q.size() - 1; g++) begin
				@(posedge pclk);
				rx_out <= {3'b000, ~buf_q[i]};
			end
		end
		@(posedge pclk);
		rx_out <= {3'b000, ~buf_q[buf_q.size() - 1]};
	endtask : send
endmodule : rx_mac_source
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the receive address filter.
// Assumes rx_filter_pkg, the filter and the MAC source model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
	typedef struct packed {
		logic [47:0] da;
		logic [15:0] tag;
		logic [7:0] rc;
		logic mc;
		logic acc;
		logic [1:0] gap;
	} row_s;
	localparam logic [47:0] STA = 48'h554433221102;
	localparam logic [47:0] UNI = 48'h564433221102;
	localparam logic [47:0] GRP = 48'h665544332201;
	localparam logic [47:0] BRD = 48'hFFFFFFFFFFFF;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [47:0] da32;
	rx_filter_pkg::rx_byte_s rx_in;
	rx_filter_pkg::filter_result_s result;
	int err_count = 0, cmp_count = 0, cycles = 0;
	int lens[4] = '{1518, 1519, 1522, 1523};
	logic [5:0] ridx[5] = '{6'h0C, 6'h1B, 6'h1C, 6'h01, 6'h17};
	row_s rows[13];

	always #4 pclk = ~pclk;

	rx_address_filter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
		.result(result));
	rx_mac_source i_mac (.pclk(pclk), .rx_out(rx_in));

	// ----------------------------------------
	// Reporting and compares
	// ----------------------------------------
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk1(input string n, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask : chk1

	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk32

	// ----------------------------------------
	// Bus and frame helpers
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) err_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wreg(input logic [5:0] i, input logic [7:0] d);
		apb(1'b1, {i, 2'b00}, {24'h0, d});
	endtask : wreg

	// Reference hash: CRC-32 over the 48 address bits, first wire bit first
	function automatic logic [5:0] hidx(input logic [47:0] da);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? rx_filter_pkg::CRC_POLY : 32'h0);
		return c[31:26];
	endfunction : hidx

	task automatic frame(input logic [47:0] da, input logic [15:0] t, input int len, input int gap);
		int n;
		i_mac.buf_q.delete();
		for (int i = 0; i < len; i++) i_mac.buf_q.push_back(i < 6 ? da[8*i+:8] : i == 12 ? t[15:8] : i == 13 ? t[7:0] : 8'(i));
		i_mac.send(gap);
		n = 0;
		while (result.decision_valid !== 1'b1 && n < 10) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 10) err_count++;
	endtask : frame

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rows = '{'{STA, 16'h0, 8'h00, 1'b0, 1'b1, 2'd0}, '{UNI, 16'h0, 8'h00, 1'b0, 1'b0, 2'd1},
			'{GRP, 16'h0, 8'h08, 1'b0, 1'b1, 2'd0}, '{GRP, 16'h0, 8'h00, 1'b0, 1'b0, 2'd2},
			'{BRD, 16'h0, 8'h04, 1'b0, 1'b1, 2'd0}, '{BRD, 16'h0, 8'h08, 1'b0, 1'b1, 2'd0},
			'{BRD, 16'h0, 8'h00, 1'b0, 1'b0, 2'd0}, '{UNI, 16'h0, 8'h10, 1'b0, 1'b1, 2'd0},
			'{STA, 16'h1234, 8'h00, 1'b1, 1'b1, 2'd0}, '{STA, 16'h1235, 8'h00, 1'b1, 1'b0, 2'd0},
			'{STA, 16'h0, 8'h00, 1'b1, 1'b1, 2'd3}, '{STA, 16'h1235, 8'h00, 1'b0, 1'b1, 2'd0},
			'{BRD, 16'h1234, 8'h04, 1'b1, 1'b1, 2'd0}};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ridx[k]) begin
			apb(1'b0, {ridx[k], 2'b00}, 32'h0);
			chk32("reset value", 32'h0, rd);
		end
		apb(1'b1, 8'h31, 32'hFF);
		chk1("misaligned err", 1'b1, er);
		apb(1'b0, 8'h00, 32'h0);
		chk1("unmapped err", 1'b1, er);
		chk32("unmapped data", 32'h0, rd);
		apb(1'b0, 8'h30, 32'h0);
		chk32("receive_config", 32'h0, rd);
		for (int k = 0; k < 6; k++) wreg(rx_filter_pkg::IDX_STATION_BASE + 6'(k), STA[8*k+:8]);
		for (int k = 0; k < 8; k++) wreg(rx_filter_pkg::IDX_HASH_BASE + 6'(k), 8'hFF);
		wreg(rx_filter_pkg::IDX_TAG_ID_HIGH, 8'h12);
		wreg(rx_filter_pkg::IDX_TAG_ID_LOW, 8'h34);
		apb(1'b0, 8'h18, 32'h0);
		chk32("station byte 5", 32'h55, rd);
		foreach (rows[r]) begin
			wreg(rx_filter_pkg::IDX_RECEIVE_CONFIG, rows[r].rc);
			wreg(rx_filter_pkg::IDX_MAC_CONFIG, {7'h0, rows[r].mc});
			frame(rows[r].da, rows[r].tag, 64, rows[r].gap);
			chk1("accept", rows[r].acc, result.overall_accept);
			chk1("unicast", rows[r].da == STA, result.unicast_hit);
			chk1("multicast", rows[r].da[0], result.multicast_hit);
			chk1("broadcast", &rows[r].da, result.broadcast_hit);
			chk1("tag", rows[r].tag == 16'h1234 || rows[r].tag == 16'h0, result.tag_id_hit);
		end
		for (int k = 0; k < 4; k++) begin
			wreg(rx_filter_pkg::IDX_MAC_CONFIG, 8'(k / 2));
			frame(STA, 16'h0, lens[k], 0);
			chk1("length_error", 1'(k % 2), result.length_error);
		end
		for (int k = 0; k < 8; k++) wreg(rx_filter_pkg::IDX_HASH_BASE + 6'(k), k == 4 ? 8'h01 : 8'h00);
		wreg(rx_filter_pkg::IDX_RECEIVE_CONFIG, 8'h08);
		wreg(rx_filter_pkg::IDX_MAC_CONFIG, 8'h00);
		da32 = 48'h1;
		while (hidx(da32) != 6'd32) da32 += 48'h2;
		frame(da32, 16'h0, 64, 0);
		chk1("index 32 accept", 1'b1, result.overall_accept);
		apb(1'b0, 8'h78, 32'h0);
		chk32("status", 32'h2015, rd & 32'h3F1F);
		frame(GRP, 16'h0, 64, 1);
		chk1("hash miss", hidx(GRP) == 6'd32, result.overall_accept);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk32("result after reset", 32'h0, 32'(result));
		presetn <= 1'b1;
		apb(1'b0, 8'h30, 32'h0);
		chk32("receive_config after reset", 32'h0, rd);
		apb(1'b0, 8'h78, 32'h0);
		chk32("status after reset", 32'h0, rd);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
